/* shared/run_ctrl_pkg.sv */
// Constants for the core run control and panic monitor.
// Assumes a 16-bit word-addressed control port and a 32-bit data path.
package run_ctrl_pkg;
    // ------------------------------------------------------------
    // Control port widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] PAUSE_OFF = 16'hF400;
    localparam logic [15:0] LAUNCH_OFF = 16'hF402;
    localparam logic [15:0] HALT_OFF = 16'hF403;
    localparam logic [15:0] ENTRY_OFF = 16'hF404;
    localparam logic [15:0] STATUS_OFF = 16'hF405;
    localparam logic [15:0] PANIC_CLR_OFF = 16'hF421;
    localparam logic [15:0] PANIC_FLAG_OFF = 16'hF427;

    // ------------------------------------------------------------
    // Memory windows on the control port
    // ------------------------------------------------------------
    localparam logic [15:0] DM0_BASE = 16'h0000;
    localparam logic [15:0] DM1_BASE = 16'h6000;
    localparam logic [15:0] PROG_BASE = 16'hC000;
    localparam logic [15:0] PROG_LAST = 16'hDFFF;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [15:0] ENTRY_RST = 16'h0000;
    localparam int CTRL_BIT = 0;
    localparam int ST_EXEC_BIT = 0;
    localparam int ST_PAUSE_BIT = 1;
    localparam int ST_NOP_BIT = 2;
    localparam int ST_HALT_BIT = 3;

    // ------------------------------------------------------------
    // Panic sources
    // ------------------------------------------------------------
    localparam int NUM_SRC = 5;
    localparam int SRC_WDOG = 0;
    localparam int SRC_MEM = 1;
    localparam int SRC_STACK = 2;
    localparam int SRC_SW = 3;
    localparam int SRC_OPCODE = 4;

    // Self-test scan address width and default depth
    localparam int BIST_AW = 14;
    localparam int BIST_DEPTH = 16384;

    // Core state, Gray coded along stopped-run-drain-idle
    typedef enum logic [1:0] {
        ST_STOPPED = 2'b00,
        ST_RUNNING = 2'b01,
        ST_DRAINING = 2'b11,
        ST_IDLE = 2'b10
    } core_state_e;
endpackage

/* shared/panic_if.sv */
// Carrier between the run control top and the panic monitor.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface panic_if;
    import run_ctrl_pkg::*;
    logic [NUM_SRC-1:0] err_src; // Error events from the core
    logic clr; // Clear all sticky flags
    logic [NUM_SRC-1:0] flags; // Sticky panic flags
    logic [BIST_AW-1:0] bist_addr; // Self-test scan address
    logic bist_fail; // Self-test found corruption

    modport top (output err_src, output clr, input flags, input bist_addr,
        output bist_fail);
    modport monitor (input err_src, input clr, output flags,
        output bist_addr, input bist_fail);
endinterface

/* rtl/panic_monitor.sv */
// Panic monitor: sticky error flags and a free-running memory self-test.
// Assumes error sources are one-cycle synchronous events.
`timescale 1ns/1ps
module panic_monitor #(
    parameter int DEPTH = run_ctrl_pkg::BIST_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    panic_if.monitor p
);
    import run_ctrl_pkg::*;

    logic [BIST_AW-1:0] scan_ff; // Current self-test address
    logic [NUM_SRC-1:0] flag_ff; // Sticky flags

    // ------------------------------------------------------------
    // Self-test scan
    // ------------------------------------------------------------
    // Walks every word forever; no host request is needed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scan_ff <= '0;
        end else if (ce) begin
            if (scan_ff == BIST_AW'(DEPTH - 1)) begin
                scan_ff <= '0;
            end else begin
                scan_ff <= scan_ff + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Sticky flags, one per source
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < NUM_SRC; i++) begin : g_flag
            logic hit;
            // Memory source also catches self-test failures
            if (i == SRC_MEM) begin : g_mem
                assign hit = p.err_src[i] | p.bist_fail;
            end else begin : g_other
                assign hit = p.err_src[i];
            end
            // Set wins over clear so no event is lost
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    flag_ff[i] <= 1'b0;
                end else if (ce) begin
                    if (hit) begin
                        flag_ff[i] <= 1'b1;
                    end else if (p.clr) begin
                        flag_ff[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign p.flags = flag_ff;
    assign p.bist_addr = scan_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    flag_sticky_a: assert property (ce && flag_ff[SRC_WDOG] && !p.clr
        |=> flag_ff[SRC_WDOG])
        else $error("watchdog flag dropped without clear");
    mem_flag_set_a: assert property (ce && p.bist_fail
        |=> flag_ff[SRC_MEM])
        else $error("self-test failure not flagged");
    set_wins_a: assert property (ce && p.clr && p.err_src[SRC_OPCODE]
        |=> flag_ff[SRC_OPCODE])
        else $error("opcode event lost under clear");
endmodule // panic_monitor

/* rtl/core_run_ctrl.sv */
// Core run control: pause, halt, launch, entry point and memory download.
// Assumes a synchronous control port with one-cycle read/write strobes.
`timescale 1ns/1ps
module core_run_ctrl #(
    parameter int SCAN_DEPTH = run_ctrl_pkg::BIST_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [run_ctrl_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [run_ctrl_pkg::DATA_W-1:0] reg_wdata,
    output logic [run_ctrl_pkg::DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic frame_done,
    input wire logic [run_ctrl_pkg::NUM_SRC-1:0] core_err,
    input wire logic bist_fail,
    output logic [run_ctrl_pkg::BIST_AW-1:0] bist_addr,
    output logic prog_we,
    output logic dm0_we,
    output logic dm1_we,
    output logic [run_ctrl_pkg::ADDR_W-1:0] mem_addr,
    output logic [run_ctrl_pkg::DATA_W-1:0] mem_wdata,
    output logic core_exec,
    output logic core_nop,
    output logic core_halted,
    output logic core_launch,
    output logic [15:0] entry_point,
    output logic [run_ctrl_pkg::NUM_SRC-1:0] panic_pins
);
    import run_ctrl_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    panic_if pif ();
    logic pause_ff; // Pause request bit
    logic launch_ff; // Launch register bit
    logic halt_ff; // Halt register bit
    logic [15:0] entry_ff; // Program entry point
    core_state_e state_ff; // Core run state
    core_state_e nxt_state; // Next core state
    logic launch_ev; // Launch edge seen this cycle
    logic wr_pause, wr_launch, wr_halt, wr_entry, wr_clr;
    logic in_prog, in_dm0, in_dm1;
    logic prog_we_ff, dm0_we_ff, dm1_we_ff;
    logic [ADDR_W-1:0] mem_addr_ff;
    logic [DATA_W-1:0] mem_wdata_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic rvalid_ff, pause_rd_ff; // Read valid; pause read in flight
    logic launch_pulse_ff, nop_ff; // Launch pulse; paused-idle flag
    logic [NUM_SRC-1:0] pins_ff;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    assign wr_pause = reg_wr && reg_addr == PAUSE_OFF;
    assign wr_launch = reg_wr && reg_addr == LAUNCH_OFF;
    assign wr_halt = reg_wr && reg_addr == HALT_OFF;
    assign wr_entry = reg_wr && reg_addr == ENTRY_OFF;
    assign wr_clr = reg_wr && reg_addr == PANIC_CLR_OFF
        && reg_wdata[CTRL_BIT];
    // Second data memory ends where program memory starts
    assign in_prog = reg_addr >= PROG_BASE && reg_addr <= PROG_LAST;
    assign in_dm0 = reg_addr < DM1_BASE;
    assign in_dm1 = reg_addr >= DM1_BASE && reg_addr < PROG_BASE;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Only the low bit is stored; upper bits are dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pause_ff <= 1'b0;
            launch_ff <= 1'b0;
            halt_ff <= 1'b0;
        end else if (ce) begin
            if (wr_pause) begin
                pause_ff <= reg_wdata[CTRL_BIT];
            end
            if (wr_launch) begin
                launch_ff <= reg_wdata[CTRL_BIT];
            end
            if (wr_halt) begin
                halt_ff <= reg_wdata[CTRL_BIT];
            end
        end
    end

    // Entry point keeps all 16 bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            entry_ff <= ENTRY_RST;
        end else if (ce && wr_entry) begin
            entry_ff <= reg_wdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // Core state machine
    // ------------------------------------------------------------
    // Launch needs a 0 to 1 edge while halt is released
    assign launch_ev = wr_launch && reg_wdata[CTRL_BIT] && !launch_ff
        && !halt_ff;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            // Waiting for a launch edge
            ST_STOPPED: begin
                if (launch_ev) begin
                    nxt_state = ST_RUNNING;
                end
            end
            // Normal processing
            ST_RUNNING: begin
                if (pause_ff) begin
                    nxt_state = ST_DRAINING;
                end
            end
            // Let the frame in flight finish
            ST_DRAINING: begin
                if (!pause_ff) begin
                    nxt_state = ST_RUNNING;
                end else if (frame_done) begin
                    nxt_state = ST_IDLE;
                end
            end
            // Only no-ops until pause is released
            ST_IDLE: begin
                if (!pause_ff) begin
                    nxt_state = ST_RUNNING;
                end
            end
            default: begin
                nxt_state = ST_STOPPED;
            end
        endcase
        // Halt overrides everything, at once
        if (halt_ff) begin
            nxt_state = ST_STOPPED;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_STOPPED;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    // Core-facing outputs, registered; pins trail the flags by one cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            launch_pulse_ff <= 1'b0;
            nop_ff <= 1'b0;
            pins_ff <= '0;
        end else if (ce) begin
            launch_pulse_ff <= state_ff == ST_STOPPED && launch_ev
                && !halt_ff;
            nop_ff <= nxt_state == ST_IDLE;
            pins_ff <= pif.flags;
        end
    end

    // ------------------------------------------------------------
    // Memory download path
    // ------------------------------------------------------------
    // Program writes are dropped unless the core is halted, so a
    // running program can never be overwritten underneath itself
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_we_ff <= 1'b0;
            dm0_we_ff <= 1'b0;
            dm1_we_ff <= 1'b0;
            mem_addr_ff <= '0;
            mem_wdata_ff <= '0;
        end else if (ce) begin
            prog_we_ff <= reg_wr && in_prog && halt_ff;
            dm0_we_ff <= reg_wr && in_dm0;
            dm1_we_ff <= reg_wr && in_dm1;
            if (reg_wr) begin
                mem_addr_ff <= reg_addr;
                mem_wdata_ff <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Register read-back
    // ------------------------------------------------------------
    // Unmapped addresses and memory windows read as zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= '0;
            rvalid_ff <= 1'b0;
            pause_rd_ff <= 1'b0;
        end else if (ce) begin
            rvalid_ff <= reg_rd;
            pause_rd_ff <= reg_rd && reg_addr == PAUSE_OFF;
            rdata_ff <= '0;
            if (reg_rd) begin
                case (reg_addr)
                    PAUSE_OFF: rdata_ff[CTRL_BIT] <= pause_ff;
                    LAUNCH_OFF: rdata_ff[CTRL_BIT] <= launch_ff;
                    HALT_OFF: rdata_ff[CTRL_BIT] <= halt_ff;
                    ENTRY_OFF: rdata_ff[15:0] <= entry_ff;
                    STATUS_OFF: begin
                        rdata_ff[ST_EXEC_BIT] <= core_exec;
                        rdata_ff[ST_PAUSE_BIT] <= pause_ff;
                        rdata_ff[ST_NOP_BIT] <= state_ff == ST_IDLE;
                        rdata_ff[ST_HALT_BIT] <= halt_ff;
                    end
                    PANIC_FLAG_OFF: begin
                        rdata_ff[NUM_SRC-1:0] <= pif.flags;
                    end
                    default: rdata_ff <= '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Panic monitor and pins
    // ------------------------------------------------------------
    assign pif.err_src = core_err;
    assign pif.clr = ce && wr_clr;
    assign pif.bist_fail = bist_fail;

    panic_monitor #(
        .DEPTH(SCAN_DEPTH)
    ) u_panic (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .p(pif)
    );

    assign reg_rdata = rdata_ff;
    assign reg_rvalid = rvalid_ff;
    assign bist_addr = pif.bist_addr;
    assign prog_we = prog_we_ff;
    assign dm0_we = dm0_we_ff;
    assign dm1_we = dm1_we_ff;
    assign mem_addr = mem_addr_ff;
    assign mem_wdata = mem_wdata_ff;
    assign core_exec = state_ff[0]; // Set in running and draining codes
    assign core_nop = nop_ff;
    assign core_halted = halt_ff;
    assign core_launch = launch_pulse_ff;
    assign entry_point = entry_ff;
    assign panic_pins = pins_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    halt_stops_a: assert property (ce && wr_halt && reg_wdata[0]
        |=> ##1 state_ff == ST_STOPPED)
        else $error("halt did not stop the core");
    launch_edge_a: assert property (launch_pulse_ff
        |-> $past(state_ff) == ST_STOPPED && !$past(launch_ff))
        else $error("launch without a rising edge from stop");
    prog_guard_a: assert property (prog_we_ff |-> $past(halt_ff))
        else $error("program write while not halted");
    drain_idle_a: assert property (ce && state_ff == ST_DRAINING
        && pause_ff && frame_done && !halt_ff
        |=> state_ff == ST_IDLE)
        else $error("paused core did not go idle after frame");
    pause_read_a: assert property (pause_rd_ff
        |-> rdata_ff[DATA_W-1:1] == '0)
        else $error("pause read has nonzero upper bits");
endmodule // core_run_ctrl

/* verification/host_port_model.sv */
// Host side of the control port: single-word writes and reads.
// Assumes the device takes a strobe on a rising clk edge with ce high.
`timescale 1ns/1ps
module host_port_model (
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [run_ctrl_pkg::ADDR_W-1:0] reg_addr,
    output logic [run_ctrl_pkg::DATA_W-1:0] reg_wdata,
    input wire logic [run_ctrl_pkg::DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid
);
    import run_ctrl_pkg::*;

    // ------------------------------------------------------------
    // Idle bus
    // ------------------------------------------------------------
    // Quiet strobes from time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
    end

    // ------------------------------------------------------------
    // Accesses
    // ------------------------------------------------------------
    // One write; address and data go inverted after the take edge
    // so that a device latching late picks up garbage, not a match
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    // One read; data is taken only if the answer is flagged valid
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = (reg_rvalid === 1'b1) ? reg_rdata : 'x;
    endtask
endmodule // host_port_model

/* verification/core_run_ctrl_tb.sv */
// Self-checking bench for the core run control block.
// Assumes the host model in host_port_model.sv and a small scan depth.
`timescale 1ns/1ps
module core_run_ctrl_tb;
    import run_ctrl_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int DEPTH = 8; // Short scan so the wrap is quick
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic frame_done = 1'b0;
    logic [NUM_SRC-1:0] core_err = '0;
    logic bist_fail = 1'b0;
    logic reg_wr, reg_rd, reg_rvalid;
    logic [ADDR_W-1:0] reg_addr, mem_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, mem_wdata;
    logic [BIST_AW-1:0] bist_addr;
    logic prog_we, dm0_we, dm1_we, core_exec, core_nop;
    logic core_halted, core_launch;
    logic [15:0] entry_point;
    logic [NUM_SRC-1:0] panic_pins, acc;
    logic [BIST_AW-1:0] held;
    int err_total = 0;
    int checks_done = 0;

    always #5 clk = ~clk; // 100 MHz

    core_run_ctrl #(.SCAN_DEPTH(DEPTH)) core_run_ctrl_inst (
        .clk(clk), .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .frame_done(frame_done), .core_err(core_err),
        .bist_fail(bist_fail), .bist_addr(bist_addr),
        .prog_we(prog_we), .dm0_we(dm0_we), .dm1_we(dm1_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .core_exec(core_exec), .core_nop(core_nop),
        .core_halted(core_halted), .core_launch(core_launch),
        .entry_point(entry_point), .panic_pins(panic_pins));

    host_port_model host_port_model_inst (
        .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Compare and count
    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        host_port_model_inst.wr(a, d);
    endtask

    task automatic rdchk(input string what, input logic [15:0] a,
        input logic [31:0] exp);
        logic [31:0] d;
        host_port_model_inst.rd(a, d);
        chk(what, d, exp);
    endtask

    // One-cycle pulse on the core-side event inputs
    task automatic evt(input logic [4:0] e, input logic bf,
        input logic fd);
        @(negedge clk);
        core_err = e;
        bist_fail = bf;
        frame_done = fd;
        @(negedge clk);
        core_err = '0;
        bist_fail = 1'b0;
        frame_done = 1'b0;
    endtask

    // Cuts a hang short; the run needs about 5140 cycles
    initial begin
        #200_000;
        err_total++;
        stop_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        // Reset state and an unmapped address
        rdchk("pause", PAUSE_OFF, 0);
        rdchk("halt", HALT_OFF, 0);
        rdchk("entry", ENTRY_OFF, ENTRY_RST);
        rdchk("status", STATUS_OFF, 0);
        rdchk("unmapped", 16'hF4FF, 0);
        // Program window is closed while the halt bit is clear
        wr(PROG_BASE, 32'h1234_5678);
        chk("prog_we open", prog_we, 0);
        // First launch from the stopped state
        wr(HALT_OFF, 0);
        wr(LAUNCH_OFF, 0);
        wr(LAUNCH_OFF, 1);
        chk("launch", core_launch, 1);
        @(negedge clk);
        chk("launch end", core_launch, 0);
        chk("exec", core_exec, 1);
        // Halt while running stops at once
        wr(HALT_OFF, 1);
        chk("halted", core_halted, 1);
        @(negedge clk);
        chk("exec halt", core_exec, 0);
        // A launch edge is ignored while halted
        wr(LAUNCH_OFF, 0);
        wr(LAUNCH_OFF, 1);
        chk("launch halted", core_launch, 0);
        wr(HALT_OFF, 0);
        wr(LAUNCH_OFF, 0);
        wr(LAUNCH_OFF, 1);
        chk("relaunch", core_launch, 1);
        rdchk("status run", STATUS_OFF, 1 << ST_EXEC_BIT);
        // Pause with upper bits set: only bit 0 counts
        wr(PAUSE_OFF, 32'hFFFF_FFFF);
        rdchk("pause on", PAUSE_OFF, 1);
        chk("draining", core_exec, 1);
        chk("no nop yet", core_nop, 0);
        evt('0, 1'b0, 1'b1);
        chk("nop", core_nop, 1);
        chk("exec drained", core_exec, 0);
        rdchk("status pause", STATUS_OFF,
            (1 << ST_PAUSE_BIT) | (1 << ST_NOP_BIT));
        // Parameter-only update under pause; program stays closed
        wr(DM0_BASE + 16'h0003, 32'hAAAA_5555);
        chk("dm0_we", dm0_we, 1);
        chk("dm0 addr", mem_addr, DM0_BASE + 16'h0003);
        chk("dm0 data", mem_wdata, 32'hAAAA_5555);
        wr(DM1_BASE + 16'h0005, 32'h0F0F_F0F0);
        chk("dm1_we", dm1_we, 1);
        chk("dm1 addr", mem_addr, DM1_BASE + 16'h0005);
        wr(PROG_BASE, 32'h1);
        chk("prog paused", prog_we, 0);
        // Full reprogram: halt, both ends of the program window
        wr(HALT_OFF, 1);
        wr(PROG_BASE, 32'hC0DE_0001);
        chk("prog_we", prog_we, 1);
        chk("prog addr", mem_addr, PROG_BASE);
        chk("prog data", mem_wdata, 32'hC0DE_0001);
        wr(PROG_LAST, 32'hC0DE_0002);
        chk("prog last", mem_addr, PROG_LAST);
        wr(ENTRY_OFF, 32'hFFFF_1234);
        chk("entry pin", entry_point, 16'h1234);
        rdchk("entry", ENTRY_OFF, 32'h0000_1234);
        wr(HALT_OFF, 0);
        rdchk("halt off", HALT_OFF, 0);
        wr(LAUNCH_OFF, 0);
        wr(LAUNCH_OFF, 1);
        chk("launch new", core_launch, 1);
        repeat (5000) @(negedge clk);
        wr(PAUSE_OFF, 0);
        @(negedge clk);
        chk("resumed", core_exec, 1);
        chk("nop off", core_nop, 0);
        // Every error source, sticky flags and pins
        acc = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            evt(5'(1 << i), 1'b0, 1'b0);
            acc = acc | 5'(1 << i);
            @(negedge clk);
            chk("pins", 32'(panic_pins), 32'(acc));
            rdchk("flags", PANIC_FLAG_OFF, 32'(acc));
        end
        wr(PANIC_CLR_OFF, 1);
        rdchk("flags clr", PANIC_FLAG_OFF, 0);
        chk("pins clr", panic_pins, 0);
        evt('0, 1'b1, 1'b0);
        rdchk("mem flag", PANIC_FLAG_OFF, 1 << SRC_MEM);
        // Event held across the clear edge: the event must win
        core_err = 5'(1 << SRC_OPCODE);
        wr(PANIC_CLR_OFF, 1);
        core_err = '0;
        rdchk("set wins", PANIC_FLAG_OFF, 1 << SRC_OPCODE);
        // Self-test scan wraps and freezes with ce low
        for (int n = 0; n < 20 && bist_addr !== 14'(DEPTH - 1); n++)
            @(negedge clk);
        @(negedge clk);
        chk("scan wrap", bist_addr, 0);
        ce = 1'b0;
        held = bist_addr;
        repeat (3) @(negedge clk);
        chk("scan frozen", bist_addr, held);
        ce = 1'b1;
        @(negedge clk);
        chk("scan on", bist_addr, held + 14'd1);
        stop_test();
    end
endmodule // core_run_ctrl_tb
